// >>> dv/loe_exec_assertions.sv
// checker for the logic-op and nv-store execution unit
`default_nettype none
module loe_chk
    import loe_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire loe_req_type req,
    input wire logic [DATA_W-1:0] op_a,
    input wire logic [DATA_W-1:0] op_b,
    input wire logic [7:0] ram_ptr,
    input wire logic busy,
    input wire logic done,
    input wire logic [2:0] pc_advance,
    input wire loe_wb_type wb,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic nv_we,
    input wire logic [NV_ADDR_W-1:0] nv_addr,
    input wire logic [7:0] nv_data,
    input wire logic nv_range_err
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // a request counts only when the unit is idle
    wire logic iss = req_valid && !busy && !done;
    wire logic lop = iss && (req.op == LOE_OP_NOR || req.op == LOE_OP_OR);
    property p_nop; iss && req.op == LOE_OP_NOP
        |=> done && !wb.we && !nv_we && pc_advance == LEN_NOP; endproperty
    a_nop: assert property (p_nop) else $error("nop retire wrong");
    property p_reg; lop && !req.use_imm
        |-> ##3 done && wb.we && pc_advance == LEN_REG; endproperty
    a_reg: assert property (p_reg) else $error("reg op timing");
    property p_imm; lop && req.use_imm
        |-> ##6 done && wb.we && pc_advance == LEN_IMM; endproperty
    a_imm: assert property (p_imm) else $error("imm op timing");
    property p_nor; iss && req.op == LOE_OP_NOR && !req.use_imm
        |-> ##3 wb.data == ~($past(op_a, 3) | $past(op_b, 3)); endproperty
    a_nor: assert property (p_nor) else $error("nor result");
    property p_or; iss && req.op == LOE_OP_OR && req.use_imm
        |-> ##6 wb.data == ($past(op_a, 6) | $past(req.imm, 6)); endproperty
    a_or: assert property (p_or) else $error("or result");
    // flags follow the written result only
    property p_flag; wb.we
        |-> wb.sign == wb.data[DATA_W-1]
        && wb.zero == (wb.data == '0); endproperty
    a_flag: assert property (p_flag) else $error("flags wrong");
    property p_store; iss && req.op == LOE_OP_STORE && ram_ptr <= NV_MAX_ADDR
        |=> nv_we && stack_push && nv_addr == $past(ram_ptr[6:0])
        && nv_data == $past(op_a[7:0]); endproperty
    a_store: assert property (p_store) else $error("store start");
    property p_pop; stack_pop
        |-> done && !wb.we && pc_advance == LEN_STORE; endproperty
    a_pop: assert property (p_pop) else $error("store retire");
    // the store keeps the core stalled from its first cycle
    property p_hold; stack_push |-> busy && !done && !stack_pop; endproperty
    a_hold: assert property (p_hold) else $error("store not held");
    // a pointer past the array writes nothing and borrows no stack
    property p_range; iss && req.op == LOE_OP_STORE && ram_ptr > NV_MAX_ADDR
        |=> nv_range_err && done && !nv_we && !stack_push
        && pc_advance == LEN_STORE; endproperty
    a_range: assert property (p_range) else $error("bad pointer");
    c_nop: cover property (iss && req.op == LOE_OP_NOP);
    c_imm: cover property (lop && req.use_imm);
    c_pop: cover property (stack_pop);
    c_range: cover property (nv_range_err);
endmodule
bind loe_exec loe_chk chk_u (
    .clk(clk),
    .resetn(resetn),
    .req_valid(req_valid),
    .req(req),
    .op_a(op_a),
    .op_b(op_b),
    .ram_ptr(ram_ptr),
    .busy(busy),
    .done(done),
    .pc_advance(pc_advance),
    .wb(wb),
    .stack_push(stack_push),
    .stack_pop(stack_pop),
    .nv_we(nv_we),
    .nv_addr(nv_addr),
    .nv_data(nv_data),
    .nv_range_err(nv_range_err)
);
`default_nettype wire

// >>> dv/logic_ops_eeprom_store_exec_test.sv
// self-checking bench for the logic-op and nv-store execution unit
`default_nettype none
module logic_ops_eeprom_store_exec_test import loe_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, resetn = 0, req_valid = 0, nv_done = 0;
    loe_req_type req = '0;
    logic [23:0] op_a = '0, op_b = '0;
    logic [7:0] ram_ptr = '0;
    logic [3:0] lag = '0; // short write time keeps the run brief
    logic busy, done, stack_push, stack_pop, nv_we, nv_range_err;
    logic [2:0] pc_advance;
    loe_wb_type wb;
    logic [6:0] nv_addr;
    logic [7:0] nv_data;
    logic saw_we, saw_nv, saw_push, saw_busy;
    logic mute = 0; // stand-in stays silent, the timer must retire
    int err_count = 0, total_checks = 0, cyc;
    localparam int SIM_WRITE = 20; // short fallback write time
    loe_exec #(.WRITE_CYCLES(SIM_WRITE)) dut_u (
        .clk(clk),
        .resetn(resetn),
        .req_valid(req_valid),
        .req(req),
        .op_a(op_a),
        .op_b(op_b),
        .ram_ptr(ram_ptr),
        .nv_done(nv_done),
        .busy(busy),
        .done(done),
        .pc_advance(pc_advance),
        .wb(wb),
        .stack_push(stack_push),
        .stack_pop(stack_pop),
        .nv_we(nv_we),
        .nv_addr(nv_addr),
        .nv_data(nv_data),
        .nv_range_err(nv_range_err)
    );
    initial forever #12.5 clk = ~clk;
    // nv memory stand-in: finishes five cycles after a write starts
    always @(posedge clk) begin
        lag <= {lag[2:0], nv_we};
        nv_done <= lag[3] && !mute;
    end
    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // issue one request, count cycles to retirement, note side outputs
    task automatic run(loe_op_type op, logic im, logic [23:0] a, b, k,
            logic [7:0] p);
        @(posedge clk);
        req_valid <= 1;
        req <= '{op, 2'h1, 2'h2, im, k};
        op_a <= a;
        op_b <= b;
        ram_ptr <= p;
        {saw_we, saw_nv, saw_push, saw_busy} = '0;
        for (cyc = 1; cyc < 60; cyc++) begin
            @(posedge clk);
            req_valid <= 0;
            #1;
            saw_we |= wb.we;
            saw_nv |= nv_we;
            saw_push |= stack_push;
            saw_busy |= busy;
            if (done === 1'b1) return;
        end
        err_count++;
        give_verdict();
    endtask
    task automatic t_nop();
        run(LOE_OP_NOP, 0, 24'hFFFFFF, 24'hFFFFFF, 0, 8'h05);
        chk("nop cycles", 1, 24'(cyc));
        chk("nop length", LEN_NOP, pc_advance);
        chk("nop side", 0, {saw_we, saw_nv, saw_push, saw_busy});
    endtask
    // both ops, both operand kinds; sign and zero results included
    task automatic t_logic();
        loe_op_type o[4] = '{LOE_OP_NOR, LOE_OP_NOR, LOE_OP_OR, LOE_OP_OR};
        logic [23:0] a[4] = '{0, 24'hFFFFFF, 24'h123456, 24'h000F0F};
        logic [23:0] b[4] = '{0, 24'h000000, 24'h800000, 24'hF0F000};
        logic [23:0] r;
        for (int i = 0; i < 4; i++) begin
            // immediate ops get op_b = ~constant; register ops pass the same value as op_b and constant
            run(o[i], i[0], a[i], i[0] ? ~b[i] : b[i], b[i], 8'h00);
            r = (o[i] == LOE_OP_NOR) ? ~(a[i] | b[i]) : a[i] | b[i];
            chk("cycles", i[0] ? 6 : 3, 24'(cyc));
            chk("length", i[0] ? LEN_IMM : LEN_REG, pc_advance);
            chk("result", r, wb.data);
            chk("flags", {2'h1, r[23], r == 0},
                {wb.dst, wb.sign, wb.zero});
            chk("busy", 2'h2, {saw_busy, busy});
        end
    endtask
    task automatic t_store(logic [7:0] p);
        run(LOE_OP_STORE, 0, 24'hABCD5A, 0, 0, p);
        chk("st length", LEN_STORE, pc_advance);
        chk("st write", !p[7], saw_nv);
        chk("st stack", {!p[7], !p[7]}, {saw_push, stack_pop});
        chk("st range", p[7], nv_range_err);
        chk("st busy", {!p[7], 1'b0}, {saw_busy, busy});
        if (!p[7]) begin
            chk("st cycles", 7, 24'(cyc));
            chk("st nv", {p[6:0], 8'h5A}, {nv_addr, nv_data});
        end
    endtask
    // macro stays silent: the fallback timer retires the store
    task automatic t_slow();
        mute = 1;
        run(LOE_OP_STORE, 0, 24'h0000C3, 0, 0, 8'h11);
        mute = 0;
        chk("slow cycles", 24'(SIM_WRITE + 1), 24'(cyc));
        chk("slow retire", {LEN_STORE, 1'b1}, {pc_advance, stack_pop});
        chk("slow nv", {7'h11, 8'hC3}, {nv_addr, nv_data});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1;
        t_nop();
        t_logic();
        // stores stand alone, never behind a skip opcode
        t_store(8'h00);
        t_store(8'h7F);
        t_store(8'h80);
        t_slow();
        t_nop();
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> pkg/loe_pkg.sv
// package for the logic-op and nv-store execution unit
// What this block does
// RQ1 - nop: one byte, one cycle, no effect
// RQ2 - nor: p1 := ~(p1|p2), only S Z
// RQ3 - nor: 2 bytes 3 cycles, 5 bytes 6
// RQ4 - or: p1 := p1|p2, only S Z
// RQ5 - or: 2 bytes 3 cycles, 5 bytes 6
// RQ6 - store: 4 bytes, p1[7:0] to nv byte
// RQ7 - pointer 0..127 maps to nv bytes
// RQ8 - store occupies one pc stack entry
// RQ9 - software avoids store with skip opcodes
// RQ10 - no next fetch until nv write done
// RQ11 - nop changes only program counter
`default_nettype none
package loe_pkg;
    localparam int DATA_W = 24;
    localparam int NV_ADDR_W = 7;
    localparam logic [7:0] NV_MAX_ADDR = 8'h7F;
    // opcode classes seen by this unit
    typedef enum logic [2:0] {
        LOE_OP_NOP, LOE_OP_NOR, LOE_OP_OR, LOE_OP_STORE, LOE_OP_OTHER
    } loe_op_type;
    // lengths in bytes
    localparam logic [2:0] LEN_NOP = 3'h1;
    localparam logic [2:0] LEN_REG = 3'h2;
    localparam logic [2:0] LEN_IMM = 3'h5;
    localparam logic [2:0] LEN_STORE = 3'h4;
    // cycle counts
    localparam logic [2:0] CYC_NOP = 3'h1;
    localparam logic [2:0] CYC_REG = 3'h3;
    localparam logic [2:0] CYC_IMM = 3'h6;
    // nominal nv write time, microseconds, and clock rate
    localparam int NV_WRITE_US = 12500;
    localparam int CLK_MHZ = 40;
    localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
    // decoded request from the fetch stage
    typedef struct packed {
        loe_op_type op;
        logic [1:0] dst;
        logic [1:0] src;
        logic use_imm;
        logic [DATA_W-1:0] imm;
    } loe_req_type;
    // result write-back to the register file
    typedef struct packed {
        logic we;
        logic [1:0] dst;
        logic [DATA_W-1:0] data;
        logic sign;
        logic zero;
    } loe_wb_type;
endpackage
`default_nettype wire

// >>> rtl/loe_exec.sv
// execution unit for nop, nor, or and the nv-store opcode
`default_nettype none
module loe_exec
    import loe_pkg::*;
#(
    parameter int WRITE_CYCLES = NV_WRITE_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire loe_req_type req,
    input wire logic [DATA_W-1:0] op_a,
    input wire logic [DATA_W-1:0] op_b,
    input wire logic [7:0] ram_ptr,
    input wire logic nv_done,
    output logic busy,
    output logic done,
    output logic [2:0] pc_advance,
    output loe_wb_type wb,
    output logic stack_push,
    output logic stack_pop,
    output logic nv_we,
    output logic [NV_ADDR_W-1:0] nv_addr,
    output logic [7:0] nv_data,
    output logic nv_range_err
);
    // one op at a time: a request counts only while idle
    // a long nv write blocks the core; the timer bounds the wait
    // should the macro never answer
    // idle waits for issue, count paces a logic op, nvwait holds fetch
    typedef enum logic [1:0] {LOE_IDLE, LOE_COUNT, LOE_NVWAIT} loe_state_type;

    // current and next state of the sequencer
    loe_state_type state_reg, state_next;
    // cycles left for logic ops
    logic [2:0] cyc_reg, cyc_next;
    // fallback nv write timer; wide enough for the full write time
    logic [31:0] wtmr_reg, wtmr_next;
    // result, flags and target held for write-back
    loe_wb_type wb_reg, wb_next;
    // bytes the pc moves at retirement, zero otherwise
    logic [2:0] adv_reg, adv_next;
    // one-cycle retirement pulse
    logic done_reg, done_next;
    // pc stack borrow and return pulses for the store
    logic push_reg, push_next, pop_reg, pop_next;
    // nv write strobe, target byte and data
    logic nvwe_reg, nvwe_next;
    logic [NV_ADDR_W-1:0] nva_reg, nva_next;
    logic [7:0] nvd_reg, nvd_next;
    // store with a pointer beyond the nv array
    logic err_reg, err_next;
    // length of the op in flight, kept for the count state
    logic [2:0] op_len_reg;
    // registered busy level
    logic busy_reg;

    // operand select and logic results, decoded once
    // the constant rides in the request, so no extra fetch cycles here
    wire logic [DATA_W-1:0] src_val = req.use_imm ? req.imm : op_b;
    wire logic [DATA_W-1:0] or_val = op_a | src_val; // RQ4
    wire logic [DATA_W-1:0] nor_val = ~(op_a | src_val); // RQ2
    // nor and or share one pacing path
    wire logic is_logic = req.op == LOE_OP_NOR || req.op == LOE_OP_OR;
    // pointer bit 7 set means no nv byte behind it
    wire logic ptr_ok = ram_ptr <= NV_MAX_ADDR; // RQ7
    wire logic [DATA_W-1:0] res_val =
        (req.op == LOE_OP_NOR) ? nor_val : or_val;
    // cycle count and length follow the operand kind
    wire logic [2:0] op_cycles = req.use_imm ? CYC_IMM : CYC_REG; // RQ3 RQ5
    wire logic [2:0] op_len = req.use_imm ? LEN_IMM : LEN_REG; // RQ3 RQ5
    // last cycle of the fallback timer
    wire logic timer_out = wtmr_reg == 32'h00000001;

    // next-state logic
    // defaults: pulses low, held values kept
    always_comb begin
        state_next = state_reg;
        cyc_next = cyc_reg;
        wtmr_next = wtmr_reg;
        wb_next = wb_reg;
        wb_next.we = 1'b0;
        adv_next = 3'h0;
        done_next = 1'b0;
        push_next = 1'b0;
        pop_next = 1'b0;
        nvwe_next = 1'b0;
        nva_next = nva_reg;
        nvd_next = nvd_reg;
        err_next = 1'b0;
        unique case (state_reg)
            LOE_IDLE: begin
                // unknown opcodes fall through and are dropped
                if (req_valid) begin
                    if (req.op == LOE_OP_NOP) begin
                        // only the pc moves, in one cycle
                        adv_next = LEN_NOP;                    // RQ1 RQ11
                        done_next = 1'b1;                      // RQ1
                    end else if (is_logic) begin
                        // result computed at issue; held until count ends
                        // flags describe the written result only
                        wb_next.dst = req.dst;
                        wb_next.data = res_val;
                        wb_next.sign = res_val[DATA_W-1];      // RQ2 RQ4
                        wb_next.zero = res_val == '0;          // RQ2 RQ4
                        cyc_next = op_cycles - 3'h1;
                        state_next = LOE_COUNT;
                    end else if (req.op == LOE_OP_STORE) begin
                        if (ptr_ok) begin
                            // flags untouched, only nv written
                            nvwe_next = 1'b1;                  // RQ6
                            nva_next = ram_ptr[NV_ADDR_W-1:0]; // RQ7
                            nvd_next = op_a[7:0];              // RQ6
                            push_next = 1'b1;                  // RQ8
                            // arm the fallback; the macro normally wins
                            wtmr_next = 32'(WRITE_CYCLES);
                            state_next = LOE_NVWAIT;           // RQ10
                        end else begin
                            // out of range: skip write, still advance
                            err_next = 1'b1;
                            adv_next = LEN_STORE;
                            done_next = 1'b1;
                        end
                    end
                end
            end
            LOE_COUNT: begin
                // last paced cycle: write back and retire
                if (cyc_reg <= 3'h1) begin
                    wb_next.we = 1'b1;
                    adv_next = op_len_reg;
                    done_next = 1'b1;
                    state_next = LOE_IDLE;
                end else begin
                    // keep pacing
                    cyc_next = cyc_reg - 3'h1;
                end
            end
            LOE_NVWAIT: begin
                // hold fetch until the macro or the timer says done
                // whichever comes first retires the store
                wtmr_next = wtmr_reg - 32'h1;
                if (nv_done || timer_out) begin               // RQ10
                    pop_next = 1'b1;                           // RQ8
                    adv_next = LEN_STORE;                      // RQ6
                    done_next = 1'b1;
                    state_next = LOE_IDLE;
                end
            end
            // illegal code: back to idle
            default: state_next = LOE_IDLE;
        endcase
    end

    // length of the op in flight, captured at issue only
    // capturing on every idle request is harmless: count reads it later
    // nop and store never read it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_len_reg <= LEN_REG;
        end else if (state_reg == LOE_IDLE && req_valid) begin
            op_len_reg <= op_len;
        end
    end

    // state registers
    // every register returns to idle values on reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= LOE_IDLE;
            cyc_reg <= 3'h0;
            wtmr_reg <= 32'h0;
            wb_reg <= '0;
            adv_reg <= 3'h0;
            done_reg <= 1'b0;
            push_reg <= 1'b0;
            pop_reg <= 1'b0;
            nvwe_reg <= 1'b0;
            nva_reg <= '0;
            nvd_reg <= 8'h00;
            err_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            wtmr_reg <= wtmr_next;
            wb_reg <= wb_next;
            adv_reg <= adv_next;
            done_reg <= done_next;
            push_reg <= push_next;
            pop_reg <= pop_next;
            nvwe_reg <= nvwe_next;
            nva_reg <= nva_next;
            nvd_reg <= nvd_next;
            err_reg <= err_next;
        end
    end

    // busy registered: high from the cycle after issue until done
    // taken from the next state so it drops together with done
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= state_next != LOE_IDLE;
        end
    end

    // outputs come straight from registers
    assign busy = busy_reg;
    assign done = done_reg;
    assign pc_advance = adv_reg;
    assign wb = wb_reg;
    // stack and nv side
    assign stack_push = push_reg;
    assign stack_pop = pop_reg;
    assign nv_we = nvwe_reg;
    assign nv_addr = nva_reg;
    assign nv_data = nvd_reg;
    assign nv_range_err = err_reg;
endmodule
`default_nettype wire
